// File: hw/flash_protect_erase_ctrl.sv
// Purpose: Flash protection, lock regions, security bit, erase pin,
//          write buffer and command decode behind an APB slave.
// Assumes: Zero-wait APB, flash array signals synchronous to sys_clk.
// Notes:   Commands are refused while a pin erase is in progress.
//          A pin hit counts only while the pin is armed, so output
//          mode and a running erase can never start a second erase.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module flash_protect_erase_ctrl
  import flash_protect_pkg::*;
#(
  parameter int unsigned  DEB_CYCLES = 32'(`DEB_CYCLES_CALC),
  parameter int           PAGES      = `FLASH_PAGES,
  parameter int           NL         = `LOCK_BITS,
  parameter logic [31:0]  CALIB      = 32'h0000_5A5A,   // Arbitrary value
  parameter logic [127:0] UID        = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF // Arbitrary
)(
  input  logic        sys_clk,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        erase_pin_in,
  output logic        erase_pin_out,
  output logic        erase_pin_oe,
  input  logic        dbg_req,
  output logic        dbg_grant,
  input  logic        fpi_req,
  output logic        fpi_grant,
  output logic        flash_prog_req,
  output logic        flash_erase_req,
  output logic        flash_full_erase_req,
  output logic [$clog2(PAGES)-1:0] flash_page,
  input  logic        flash_done,
  output logic        flash_wide128,
  output logic [3:0]  flash_wait_states,
  input  logic [$clog2(`WBUF_BYTES/4)-1:0] buf_rd_idx,
  output logic [31:0] buf_rd_data,
  output logic        cmd_abort_irq
);
  localparam int PW  = $clog2(PAGES);
  localparam int LW  = (NL > 1) ? $clog2(NL) : 1;
  localparam int WW  = `WBUF_BYTES / 4;
  localparam int SH  = $clog2(`PAGES_PER_REGION);

  typedef struct packed {
    ctl_state_e           st;
    logic                 wide;
    logic [3:0]           ws;
    logic                 pin_gpio;
    logic                 gpio_out;
    logic [NL-1:0]        lock;
    logic                 sec;
    logic                 err;
    logic [31:0]          result;
    logic [31:0]          rdata;
    logic [31:0]          bufo;
    logic                 prog;
    logic                 erase;
    logic                 full;
    logic [PW-1:0]        page;
    logic [WW-1:0][31:0]  wbuf;
  } ctl_s;

  ctl_s ctl_reg;
  ctl_s ctl_next;

  logic          setup;
  logic          acc;
  logic          wr;
  logic          rd;
  logic          cmd_ok;
  logic [PW-1:0] cpage;
  logic [LW-1:0] creg;
  logic          locked;
  cmd_e          ccode;

  erase_if eif();

  // Erase pin filter, armed only in system function and when idle
  assign eif.level = erase_pin_in;
  assign eif.arm   = !ctl_reg.pin_gpio && ctl_reg.st == ST_IDLE;

  erase_debounce #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_deb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .eif     (eif)
  );

  // APB phase decode
  assign setup  = psel && !penable;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;

  // Command fields and lock lookup
  assign ccode  = cmd_e'(pwdata[7:0]);
  assign cpage  = pwdata[`CMD_ARG_LSB +: PW];
  assign creg   = LW'(cpage >> SH);
  assign locked = ctl_reg.lock[creg];
  assign cmd_ok = wr && paddr == `OFF_CMD && ctl_reg.st == ST_IDLE;

  // Address map check
  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    if (a[1:0] == 2'b00)
    begin
      if (a[7])
        m = 1'b1;
      else if (a <= `OFF_CAL || (a >= `OFF_UID0 && a <= `OFF_UID3))
        m = 1'b1;
    end
    return m;
  endfunction

  // Read data mux
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[7])
      v = ctl_reg.wbuf[a[6:2]];
    else
    begin
      case (a)
        `OFF_CTRL:
        begin
          v[`CTRL_WIDE]            = ctl_reg.wide;
          v[`CTRL_WS_LSB +: 4]     = ctl_reg.ws;
          v[`CTRL_PINSEL]          = ctl_reg.pin_gpio;
          v[`CTRL_GPOUT]           = ctl_reg.gpio_out;
        end
        `OFF_STAT:
        begin
          v[`STAT_READY]   = ctl_reg.st == ST_IDLE;
          v[`STAT_LOCKERR] = ctl_reg.err;
        end
        `OFF_RES:  v = ctl_reg.result;
        `OFF_LOCK: v[NL-1:0] = ctl_reg.lock;
        `OFF_GPNV: v[0] = ctl_reg.sec;
        `OFF_CAL:  v = CALIB;
        `OFF_UID0: v = UID[31:0];
        `OFF_UID1: v = UID[63:32];
        `OFF_UID2: v = UID[95:64];
        `OFF_UID3: v = UID[127:96];
        default:   v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction

  // Next-state logic
  always_comb
  begin
    ctl_next       = ctl_reg;
    ctl_next.prog  = 1'b0;
    ctl_next.erase = 1'b0;
    ctl_next.full  = 1'b0;
    ctl_next.bufo  = ctl_reg.wbuf[buf_rd_idx];
    if (setup)
      ctl_next.rdata = rd_word(paddr);
    // Lock error clears on status read
    if (rd && paddr == `OFF_STAT)
      ctl_next.err = 1'b0;
    // Register and buffer writes
    if (wr && paddr[7] && paddr[1:0] == 2'b00)
      ctl_next.wbuf[paddr[6:2]] = pwdata;
    if (wr && paddr == `OFF_CTRL)
    begin
      ctl_next.wide     = pwdata[`CTRL_WIDE];
      ctl_next.ws       = pwdata[`CTRL_WS_LSB +: 4];
      ctl_next.pin_gpio = pwdata[`CTRL_PINSEL];
      ctl_next.gpio_out = pwdata[`CTRL_GPOUT];
    end
    // Command decode, set of error wins over read clear
    if (cmd_ok)
    begin
      unique case (ccode)
        CMD_DESC:
        begin
          unique case (cpage[1:0])
            2'b00:   ctl_next.result = {16'(PAGES), 16'(`PAGE_BYTES)};
            2'b01:   ctl_next.result = {16'(NL), 16'(`PAGES_PER_REGION)};
            2'b10:   ctl_next.result = 32'(`WBUF_BYTES);
            default: ctl_next.result = 32'h0000_0000;
          endcase
        end
        CMD_PROG, CMD_ERASE:
        begin
          if (locked)
            ctl_next.err = 1'b1;
          else
          begin
            ctl_next.prog  = ccode == CMD_PROG;
            ctl_next.erase = ccode == CMD_ERASE;
            ctl_next.page  = cpage;
          end
        end
        CMD_SETLOCK: ctl_next.lock[creg] = 1'b1;
        CMD_CLRLOCK: ctl_next.lock[creg] = 1'b0;
        CMD_SETGP:   ctl_next.sec = 1'b1;
        default:     ctl_next.result = 32'hFFFF_FFFF;
      endcase
    end
    // Pin erase sequence
    unique case (ctl_reg.st)
      ST_IDLE:
        // Hit honoured only while still armed
        if (eif.hit && eif.arm)
        begin
          ctl_next.st   = ST_PIN;
          ctl_next.full = 1'b1;
        end
      ST_PIN:
        if (flash_done)
        begin
          ctl_next.lock = '0;
          ctl_next.sec  = 1'b0;
          ctl_next.st   = ST_IDLE;
        end
    endcase
  end

  // State register; pin starts in system function
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctl_reg      <= '0;
      ctl_reg.wide <= `CTRL_WIDE_RST;
      ctl_reg.ws   <= `CTRL_WS_RST;
    end
    else
      ctl_reg <= ctl_next;
  end

  // Outputs
  assign prdata               = ctl_reg.rdata;
  assign pready               = acc;
  assign pslverr              = acc && !is_mapped(paddr);
  assign erase_pin_out        = ctl_reg.gpio_out;
  assign erase_pin_oe         = ctl_reg.pin_gpio;
  assign dbg_grant            = dbg_req && !ctl_reg.sec;
  assign fpi_grant            = fpi_req && !ctl_reg.sec;
  assign flash_prog_req       = ctl_reg.prog;
  assign flash_erase_req      = ctl_reg.erase;
  assign flash_full_erase_req = ctl_reg.full;
  assign flash_page           = ctl_reg.page;
  assign flash_wide128        = ctl_reg.wide;
  assign flash_wait_states    = ctl_reg.ws;
  assign buf_rd_data          = ctl_reg.bufo;
  assign cmd_abort_irq        = ctl_reg.err;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_lock_abort: assert property (
    cmd_ok && (ccode == CMD_PROG || ccode == CMD_ERASE) && locked
    |=> cmd_abort_irq && !flash_prog_req && !flash_erase_req)
    else $error("locked command not aborted");
  a_lock_set: assert property (
    cmd_ok && ccode == CMD_SETLOCK |=> ctl_reg.lock[$past(creg)])
    else $error("set-lock did not lock region");
  a_pin_unlock: assert property (
    ctl_reg.st == ST_PIN && flash_done |=> ctl_reg.lock == '0 && !ctl_reg.sec)
    else $error("pin erase left locks or security");
  a_sec_block: assert property (
    ctl_reg.sec |-> !dbg_grant && !fpi_grant)
    else $error("access granted while secured");
  a_sec_source: assert property (
    $rose(ctl_reg.sec) |-> $past(cmd_ok && ccode == CMD_SETGP))
    else $error("security set without command");
  a_gpio_safe: assert property (
    ctl_reg.pin_gpio && $past(ctl_reg.pin_gpio) |-> !flash_full_erase_req)
    else $error("erase started in output mode");
  a_full_seq: assert property (
    flash_full_erase_req |-> ctl_reg.st == ST_PIN ##1 ctl_reg.st == ST_PIN || $past(flash_done))
    else $error("full erase without pin sequence");
  a_cmd_refused: assert property (
    ctl_reg.st == ST_PIN && !flash_done |=> !flash_prog_req && !flash_erase_req)
    else $error("command accepted during pin erase");
  a_slave_err: assert property (
    acc && !is_mapped(paddr) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // Command and lock region checks
  a_lock_clear: assert property (
    cmd_ok && ccode == CMD_CLRLOCK |=> !ctl_reg.lock[$past(creg)])
    else $error("clear-lock left region locked");
  a_region_map: assert property (
    cmd_ok && ccode == CMD_SETLOCK |=> ctl_reg.lock[$past(cpage) / `PAGES_PER_REGION])
    else $error("lock bit not chosen by page region");
  a_prog_issue: assert property (
    cmd_ok && ccode == CMD_PROG && !locked |=> flash_prog_req && flash_page == $past(cpage))
    else $error("unlocked program not issued");
  a_erase_issue: assert property (
    cmd_ok && ccode == CMD_ERASE && !locked |=> flash_erase_req && !flash_prog_req)
    else $error("unlocked erase not issued");
  a_irq_sticky: assert property (
    cmd_abort_irq && !(rd && paddr == `OFF_STAT) |=> cmd_abort_irq)
    else $error("abort interrupt dropped without status read");
  a_err_clear: assert property (
    rd && paddr == `OFF_STAT |=> !cmd_abort_irq)
    else $error("abort interrupt kept after status read");

  // Erase pin and security checks
  a_pin_start: assert property (
    eif.hit && eif.arm |=> flash_full_erase_req && ctl_reg.st == ST_PIN)
    else $error("qualified pin did not start full erase");
  a_full_once: assert property (
    flash_full_erase_req |=> !flash_full_erase_req)
    else $error("full erase request longer than one cycle");
  a_sec_hold: assert property (
    ctl_reg.sec && !(ctl_reg.st == ST_PIN && flash_done) |=> ctl_reg.sec)
    else $error("security cleared without pin erase");
  a_sec_gate: assert property (
    !ctl_reg.sec |-> dbg_grant == dbg_req && fpi_grant == fpi_req)
    else $error("access refused while unsecured");

  // Register contents checks
  a_ctrl_follow: assert property (
    wr && paddr == `OFF_CTRL |=> flash_wide128 == $past(pwdata[`CTRL_WIDE])
      && flash_wait_states == $past(pwdata[`CTRL_WS_LSB +: 4]))
    else $error("control write not applied");
  a_cal_fixed: assert property (
    setup && paddr == `OFF_CAL |=> prdata == CALIB)
    else $error("calibration word not read back unchanged");
  a_uid_fixed: assert property (
    setup && paddr == `OFF_UID3 |=> prdata == UID[127:96])
    else $error("identifier word not read back unchanged");
  a_buf_store: assert property (
    wr && paddr[7] && paddr[1:0] == 2'b00 |=> ctl_reg.wbuf[$past(paddr[6:2])] == $past(pwdata))
    else $error("write buffer word not stored");
  a_desc_geom: assert property (
    cmd_ok && ccode == CMD_DESC && cpage[1:0] == 2'b00
      |=> ctl_reg.result == {16'(PAGES), 16'(`PAGE_BYTES)})
    else $error("descriptor does not give page geometry");

  c_pin_erase: cover property (ctl_reg.st == ST_PIN ##[1:20] flash_done);
  c_lock_abort: cover property (cmd_ok && ccode == CMD_PROG && locked);
  c_set_sec: cover property ($rose(ctl_reg.sec));
  c_desc: cover property (cmd_ok && ccode == CMD_DESC);

endmodule // flash_protect_erase_ctrl

// File: shared/flash_protect_cfg.svh
// Purpose: Offsets, fields, reset values and timing for the flash
//          protection and erase controller.
// Assumes: 25 MHz system clock, APB register access, byte addresses.
// Notes:   Definitions only; the package holds the types.
//
// Functional notes
// - Ignore erase input highs shorter than 100 ms
// - Pin erase returns flash to all ones
// - Driving erase pin low as output never erases
// - Erase pin starts in system function
// - 64-page lock regions, one lock bit each
// - Locked program or erase aborts, raises interrupt
// - Set-lock protects region, clear-lock unprotects
// - Qualified erase pin clears all lock bits
// - Security bit blocks debug and fast programming
// - Security set by command, cleared by pin erase
// - Calibration bits read-only, untouched by erase
// - 128-bit unique identifier, read-only, erase-proof
// - Single bank of 256-byte pages, 1024 max
// - 128-byte write buffer through 32-bit accesses
// - Software selects 128-bit or 64-bit reads
// - Command returns flash organisation descriptor
`ifndef FLASH_PROTECT_CFG_SVH
`define FLASH_PROTECT_CFG_SVH

// Register byte offsets
`define OFF_CTRL   8'h00
`define OFF_CMD    8'h04
`define OFF_STAT   8'h08
`define OFF_RES    8'h0C
`define OFF_LOCK   8'h10
`define OFF_GPNV   8'h14
`define OFF_CAL    8'h18
`define OFF_UID0   8'h20
`define OFF_UID1   8'h24
`define OFF_UID2   8'h28
`define OFF_UID3   8'h2C
`define OFF_WBUF   8'h80

// Field positions
`define CTRL_WIDE    0
`define CTRL_WS_LSB  4
`define CTRL_PINSEL  8
`define CTRL_GPOUT   9
`define CMD_ARG_LSB  8
`define STAT_READY   0
`define STAT_LOCKERR 1

// Reset values
`define CTRL_WIDE_RST 1'b1
`define CTRL_WS_RST   4'h0

// Organisation
`define PAGE_BYTES       256
`define FLASH_PAGES      1024
`define PAGES_PER_REGION 64
`define LOCK_BITS        16
`define WBUF_BYTES       128

// Timing
`define CLK_HZ          25000000
`define ERASE_IGNORE_MS 100
`define DEB_CYCLES_CALC ((64'(`ERASE_IGNORE_MS) * 64'(`CLK_HZ)) / 64'd1000)

`endif

// File: shared/flash_protect_pkg.sv
// Purpose: Types shared by the flash protection controller files.
// Assumes: Constants come from flash_protect_cfg.svh.
// Notes:   Command codes are the low byte of a command write.
package flash_protect_pkg;

  // Controller sequencing
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_PIN   = 1'b1
  } ctl_state_e;

  // Command codes
  typedef enum logic [7:0] {
    CMD_DESC    = 8'h00,
    CMD_PROG    = 8'h01,
    CMD_ERASE   = 8'h03,
    CMD_SETLOCK = 8'h08,
    CMD_CLRLOCK = 8'h09,
    CMD_SETGP   = 8'h0B
  } cmd_e;

endpackage

// File: shared/erase_if.sv
// Purpose: Carries the erase pin level and qualified erase event.
// Assumes: Single clock domain.
// Notes:   hit is a one-cycle pulse.
`timescale 1ns/1ps
interface erase_if;
  logic level;
  logic arm;
  logic hit;

  modport deb (input level, input arm, output hit);
  modport ctl (output level, output arm, input hit);
endinterface // erase_if

// File: hw/erase_debounce.sv
// Purpose: Debounce of the erase pin level.
// Assumes: Level synchronous to sys_clk.
// Notes:   One hit per continuous armed high interval.
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module erase_debounce
  import flash_protect_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = 32'(`DEB_CYCLES_CALC)
)(
  input  logic   sys_clk,
  input  logic   rst,
  erase_if.deb   eif
);
  localparam int CW = $clog2(DEB_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
    logic          hit;
    logic [CW-1:0] hlp;
  } deb_s;

  deb_s deb_reg;
  deb_s deb_next;

  // Count armed high cycles, restart on any low
  always_comb
  begin
    deb_next     = deb_reg;
    deb_next.hit = 1'b0;
    if (!eif.level)
    begin
      deb_next.cnt  = '0;
      deb_next.done = 1'b0;
      deb_next.hlp  = '0;
    end
    else if (!eif.arm)
    begin
      deb_next.cnt = '0;  // High while busy keeps done, no second hit
      deb_next.hlp = '0;
    end
    else
    begin
      if (deb_reg.hlp != CW'(DEB_CYCLES))
        deb_next.hlp = deb_reg.hlp + 1'b1;
      if (!deb_reg.done)
      begin
        if (deb_reg.cnt == CW'(DEB_CYCLES - 1))
        begin
          deb_next.hit  = 1'b1;
          deb_next.done = 1'b1;
        end
        else
          deb_next.cnt = deb_reg.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      deb_reg <= '0;
    else
      deb_reg <= deb_next;
  end

  assign eif.hit = deb_reg.hit;

  // Checks on the filter
  a_deb_min_len: assert property (@(posedge sys_clk) disable iff (rst)
    deb_reg.hit |-> deb_reg.hlp == CW'(DEB_CYCLES))
    else $error("erase hit before full debounce time");
  a_deb_restart: assert property (@(posedge sys_clk) disable iff (rst)
    !eif.level |=> deb_reg.cnt == '0 && !deb_reg.hit)
    else $error("debounce did not restart on low");
  c_deb_hit: cover property (@(posedge sys_clk) disable iff (rst)
    deb_reg.hit);

endmodule // erase_debounce

// File: tb/flash_array_model.sv
// Purpose: Flash array stand-in answering full erase and program pulses.
// Assumes: Requests are one-cycle pulses synchronous to sys_clk.
// Notes:   Done follows a full erase after DONE_DLY cycles.
`timescale 1ns/1ps
module flash_array_model #(
  parameter int DONE_DLY = 6
)(
  input  logic        sys_clk,
  input  logic        rst,
  input  logic        prog_req,
  input  logic        full_req,
  output logic        done,
  output logic [31:0] word
);
  int cnt;

  // Erase timing and one sample word of the array
  always_ff @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (rst)
    begin
      cnt  <= 0;
      word <= 32'hFFFF_FFFF;
    end
    else if (full_req)
      cnt <= DONE_DLY;
    else if (cnt == 1)
    begin
      cnt  <= 0;
      done <= 1'b1;
      word <= 32'hFFFF_FFFF; // Erased cells read all ones
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (prog_req)
      word <= 32'h0000_0000;
  end
endmodule // flash_array_model

// File: tb/testbench.sv
// Purpose: Self-checking bench for the flash protection and erase controller.
// Assumes: Zero-wait APB slave, debounce shortened to 8 cycles.
// Notes:   One task per scenario; counters watch the array request pulses.
`timescale 1ns/1ps
`include "flash_protect_cfg.svh"
module testbench
  import flash_protect_pkg::*;
;
  localparam logic [31:0]  CAL_V = 32'h0000_3C3C; // Arbitrary
  localparam logic [127:0] UID_V = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0; // Arbitrary
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        pin_in, pin_out, pin_oe, dbg_req, dbg_gnt, fpi_req, fpi_gnt;
  logic        prog_req, erase_req, full_req, done, wide128, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, buf_data, arr_word;
  logic [9:0]  page, last_page;
  logic [3:0]  wait_states;
  logic [4:0]  buf_idx;
  int          miscompares, tests_run, cyc, n_prog, n_erase, n_full, p0, f0;

  flash_protect_erase_ctrl #(.DEB_CYCLES(8), .CALIB(CAL_V), .UID(UID_V)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .erase_pin_in(pin_in), .erase_pin_out(pin_out), .erase_pin_oe(pin_oe),
    .dbg_req(dbg_req), .dbg_grant(dbg_gnt), .fpi_req(fpi_req), .fpi_grant(fpi_gnt),
    .flash_prog_req(prog_req), .flash_erase_req(erase_req),
    .flash_full_erase_req(full_req), .flash_page(page), .flash_done(done),
    .flash_wide128(wide128), .flash_wait_states(wait_states), .buf_rd_idx(buf_idx),
    .buf_rd_data(buf_data), .cmd_abort_irq(irq));

  flash_array_model array (.sys_clk(sys_clk), .rst(rst), .prog_req(prog_req),
    .full_req(full_req), .done(done), .word(arr_word));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Request pulse counters and hang limit
  always @(posedge sys_clk)
  begin
    if (prog_req === 1'b1)
    begin
      n_prog++;
      last_page = page;
    end
    if (erase_req === 1'b1) n_erase++;
    if (full_req === 1'b1) n_full++;
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; waits for pready, result left in q and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk); // Outputs settle before callers look
  endtask

  task automatic cmd(input logic [7:0] c, input logic [9:0] pg);
    apb(1'b1, `OFF_CMD, {14'h0, pg, c});
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic pin_high(input int n);
    @(posedge sys_clk);
    pin_in <= 1'b1;
    repeat (n) @(posedge sys_clk);
    pin_in <= 1'b0;
  endtask

  task automatic t_reset();
    apb(1'b0, `OFF_CTRL, 0); chk(q, 32'h1);
    chk(32'(pin_oe), 32'h0);
    apb(1'b1, `OFF_CAL, 0); apb(1'b0, `OFF_CAL, 0); chk(q, CAL_V);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 8'(`OFF_UID0 + 4 * i), 0); chk(q, UID_V[32 * i +: 32]);
    end
    apb(1'b0, 8'h40, 0); chk({31'h0, err}, 32'h1);
    apb(1'b1, `OFF_LOCK, 32'hFFFF); apb(1'b0, `OFF_LOCK, 0); chk(q, 32'h0);
  endtask

  task automatic t_ctrl();
    apb(1'b1, `OFF_CTRL, 32'h50);
    chk(32'(wide128), 32'h0);
    chk(32'(wait_states), 32'h5);
    apb(1'b1, `OFF_CTRL, 32'h1); chk(32'(wide128), 32'h1);
  endtask

  task automatic t_lock();
    cmd(CMD_SETLOCK, 10'd64); apb(1'b0, `OFF_LOCK, 0); chk(q, 32'h2);
    p0 = n_prog;
    cmd(CMD_PROG, 10'd127); chk(32'(n_prog), 32'(p0));
    chk(32'(irq), 32'h1);
    apb(1'b0, `OFF_STAT, 0); chk(q, 32'h3);
    p0 = n_erase;
    cmd(CMD_ERASE, 10'd64); chk(32'(n_erase), 32'(p0));
    apb(1'b0, `OFF_STAT, 0); chk(q, 32'h3);
    @(posedge sys_clk); chk(32'(irq), 32'h0);
    cmd(CMD_PROG, 10'd63); chk(32'(last_page), 32'd63);
    cmd(CMD_CLRLOCK, 10'd100); apb(1'b0, `OFF_LOCK, 0); chk(q, 32'h0);
    cmd(CMD_PROG, 10'd127); chk(32'(last_page), 32'd127);
    p0 = n_erase;
    cmd(CMD_ERASE, 10'd5); chk(32'(n_erase), 32'(p0 + 1));
    cmd(CMD_SETLOCK, 10'd1023); apb(1'b0, `OFF_LOCK, 0); chk(q, 32'h8000);
  endtask

  task automatic t_buf_desc();
    apb(1'b1, `OFF_WBUF, 32'hA5A5_0001);
    apb(1'b1, 8'hFC, 32'h5A5A_0002);
    @(posedge sys_clk);
    buf_idx <= 5'd31;
    repeat (2) @(posedge sys_clk);
    chk(buf_data, 32'h5A5A_0002);
    apb(1'b0, `OFF_WBUF, 0); chk(q, 32'hA5A5_0001);
    cmd(8'h77, 10'd0); apb(1'b0, `OFF_RES, 0); chk(q, 32'hFFFF_FFFF);
    cmd(CMD_DESC, 10'd2); apb(1'b0, `OFF_RES, 0); chk(q, 32'd128);
    cmd(CMD_DESC, 10'd0); apb(1'b0, `OFF_RES, 0);
    chk(q, {16'(`FLASH_PAGES), 16'(`PAGE_BYTES)});
    cmd(CMD_DESC, 10'd1); apb(1'b0, `OFF_RES, 0);
    chk(q, {16'(`LOCK_BITS), 16'(`PAGES_PER_REGION)});
  endtask

  task automatic t_sec();
    @(posedge sys_clk);
    dbg_req <= 1'b1;
    fpi_req <= 1'b1;
    repeat (2) @(posedge sys_clk); chk({30'h0, dbg_gnt, fpi_gnt}, 32'h3);
    cmd(CMD_SETGP, 10'd0); apb(1'b0, `OFF_GPNV, 0); chk(q, 32'h1);
    chk({30'h0, dbg_gnt, fpi_gnt}, 32'h0);
  endtask

  task automatic t_pin();
    f0 = n_full;
    apb(1'b1, `OFF_CTRL, 32'h301); chk({30'h0, pin_oe, pin_out}, 32'h3);
    pin_high(20); chk(32'(n_full), 32'(f0));
    apb(1'b1, `OFF_CTRL, 32'h1);
    pin_high(6);
    pin_high(6);
    repeat (4) @(posedge sys_clk); chk(32'(n_full), 32'(f0));
    chk(arr_word, 32'h0);
    pin_high(20);                                         // Beyond the long hold
    repeat (12) @(posedge sys_clk); chk(32'(n_full), 32'(f0 + 1));
    chk(arr_word, 32'hFFFF_FFFF);
    apb(1'b0, `OFF_LOCK, 0); chk(q, 32'h0);
    apb(1'b0, `OFF_GPNV, 0); chk(q, 32'h0);
    chk({30'h0, dbg_gnt, fpi_gnt}, 32'h3);
    apb(1'b0, `OFF_CAL, 0); chk(q, CAL_V);
    apb(1'b0, `OFF_UID3, 0); chk(q, UID_V[127:96]);
  endtask

  // Main sequence
  initial
  begin
    {rst, psel, penable, pwrite, pin_in, dbg_req, fpi_req} = 7'b1000000;
    {paddr, pwdata, buf_idx} = '0;
    {miscompares, tests_run, cyc, n_prog, n_erase, n_full} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_lock();
    t_buf_desc();
    t_sec();
    t_pin();
    close_out();
  end
endmodule // testbench
